// file: design/smbpc_pkg.sv
package smbpc_pkg;

    localparam logic [7:0] ADDR_CMD_CODE    = 8'h99;
    localparam logic [7:0] ADDR_RESULT_BASE = 8'ha8;
    localparam logic [7:0] ADDR_RS          = 8'hb0;
    localparam logic [7:0] ADDR_PEC         = 8'hb1;
    localparam logic [7:0] ADDR_FMT_LO      = 8'hb2;
    localparam logic [7:0] ADDR_FMT_HI      = 8'hb3;
    localparam logic [7:0] ADDR_CTL         = 8'hb5;
    localparam logic [7:0] ADDR_NACK        = 8'hb6;
    localparam logic [7:0] ADDR_PEC_ERR     = 8'hb7;
    localparam logic [7:0] ADDR_TIMEOUT     = 8'hb8;
    localparam logic [7:0] ADDR_LIMIT       = 8'hb9;
    localparam logic [7:0] ADDR_INVALID     = 8'hba;
    localparam logic [7:0] ADDR_NACK_MASK   = 8'hbc;
    localparam logic [7:0] ADDR_HIGH_LIM    = 8'hc1;
    localparam logic [7:0] ADDR_LOW_LIM     = 8'hc2;

    localparam logic [7:0] RST_RS       = 8'hff;
    localparam logic [7:0] RST_PEC      = 8'h00;
    localparam logic [7:0] RST_FMT_LO   = 8'h03;
    localparam logic [7:0] RST_FMT_HI   = 8'h00;
    localparam logic [7:0] RST_CTL      = 8'h08;
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [7:0] RST_RESULT   = 8'h80;
    localparam logic [7:0] RST_CMD_CODE = 8'h40;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_HIGH_LIM = 8'h7f;
    localparam logic [7:0] RST_LOW_LIM  = 8'h81;

    localparam int CTL_EN_BIT   = 0;
    localparam int CTL_HYS_LSB  = 1;
    localparam int CTL_REMA_BIT = 5;
    localparam int CTL_REMB_BIT = 6;
    localparam int CTL_HUB_BIT  = 7;

    localparam logic [7:0] INVALID_USED_MASK = 8'h1f;
    localparam logic [7:0] RESERVED_TEMP_CODE = 8'hff;

    localparam int BUS_TIMEOUT_MS   = 25;
    localparam int SYS_CLK_KHZ      = 100000;
    localparam int BUS_TIMEOUT_CYC  = BUS_TIMEOUT_MS * SYS_CLK_KHZ;

    typedef enum logic [1:0] {
        FMT_TWOS     = 2'b00,
        FMT_JEDEC    = 2'b01,
        FMT_UNSIGNED = 2'b10,
        FMT_SPECIAL  = 2'b11
    } smbpc_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ISSUE  = 2'b01,
        ST_WAIT   = 2'b10,
        ST_UPDATE = 2'b11
    } smbpc_state_t;

    typedef struct packed {
        logic [2:0] slave;
        logic       repStart;
        logic       pecEn;
        smbpc_fmt_t fmt;
        logic       blockRead;
        logic       literal;
        logic       fromHub;
        logic [7:0] blockCmd;
    } smbpc_req_t;

    typedef struct packed {
        logic [2:0]  slave;
        logic        noAck;
        logic        pecErr;
        logic        timeout;
        logic [15:0] data;
    } smbpc_res_t;

endpackage : smbpc_pkg

// file: design/smbpc_result_mem.sv
`timescale 1ns/1ns
`default_nettype none

module smbpc_result_mem
    import smbpc_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
)(
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output var  logic [WIDTH-1:0]         rdData
);

    logic [WIDTH-1:0] mem_reg  [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [WIDTH-1:0] rdData_next;

    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem_next[i] = mem_reg[i];
        end
        if (wrEn)
        begin
            mem_next[wrAddr] = wrData;
        end
        rdData_next = mem_reg[rdAddr];
    end

    // Each slot holds the not-yet-polled marker until its first good reading
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= WIDTH'(RST_RESULT);
            end
            rdData <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
            rdData  <= rdData_next;
        end
    end

endmodule : smbpc_result_mem

`default_nettype wire

// file: design/smbpc_top.sv
`timescale 1ns/1ns
`default_nettype none

module smbpc_top
    import smbpc_pkg::*;
#(
    parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
)(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output var  logic [7:0] regRdData,
    output var  logic       regRdValid,
    input  wire logic       sclPin,
    input  wire logic [7:0] remoteTempA,
    input  wire logic [7:0] remoteTempB,
    input  wire logic       pollDone,
    input  var  smbpc_res_t pollResult,
    output var  smbpc_req_t pollReq,
    output var  logic       pollStart,
    output var  logic       pollAbort,
    output var  logic       nackAlert
);

    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

    function automatic smbpc_fmt_t fmtOf(input logic [2:0] s, input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [7:0] r;
        r = s[2] ? hi : lo;
        return smbpc_fmt_t'(r[{s[1:0], 1'b0} +: 2]);
    endfunction : fmtOf

    function automatic logic isDimm(input logic [2:0] s);
        return (s >= 3'h1) && (s <= 3'h4);
    endfunction : isDimm

    // Configuration registers
    logic [7:0] rs_reg, rs_next, pec_reg, pec_next, fmtLo_reg, fmtLo_next;
    logic [7:0] fmtHi_reg, fmtHi_next, ctl_reg, ctl_next, cmd_reg, cmd_next;
    logic [7:0] mask_reg, mask_next, hiLim_reg, hiLim_next, loLim_reg, loLim_next;

    always_comb
    begin
        rs_next    = rs_reg;
        pec_next   = pec_reg;
        fmtLo_next = fmtLo_reg;
        fmtHi_next = fmtHi_reg;
        ctl_next   = ctl_reg;
        cmd_next   = cmd_reg;
        mask_next  = mask_reg;
        hiLim_next = hiLim_reg;
        loLim_next = loLim_reg;
        if (regWr)
        begin
            case (regAddr)
                ADDR_RS:        rs_next    = regWrData;
                ADDR_PEC:       pec_next   = regWrData;
                ADDR_FMT_LO:    fmtLo_next = regWrData;
                ADDR_FMT_HI:    fmtHi_next = regWrData;
                ADDR_CTL:       ctl_next   = regWrData;
                ADDR_CMD_CODE:  cmd_next   = regWrData;
                ADDR_NACK_MASK: mask_next  = regWrData;
                ADDR_HIGH_LIM:  hiLim_next = regWrData;
                ADDR_LOW_LIM:   loLim_next = regWrData;
                default:        rs_next    = rs_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rs_reg    <= RST_RS;
            pec_reg   <= RST_PEC;
            fmtLo_reg <= RST_FMT_LO;
            fmtHi_reg <= RST_FMT_HI;
            ctl_reg   <= RST_CTL;
            cmd_reg   <= RST_CMD_CODE;
            mask_reg  <= RST_MASK;
            hiLim_reg <= RST_HIGH_LIM;
            loLim_reg <= RST_LOW_LIM;
        end
        else
        begin
            rs_reg    <= rs_next;
            pec_reg   <= pec_next;
            fmtLo_reg <= fmtLo_next;
            fmtHi_reg <= fmtHi_next;
            ctl_reg   <= ctl_next;
            cmd_reg   <= cmd_next;
            mask_reg  <= mask_next;
            hiLim_reg <= hiLim_next;
            loLim_reg <= loLim_next;
        end
    end

    wire logic       masterEn = ctl_reg[CTL_EN_BIT];
    wire logic [3:0] hys      = ctl_reg[CTL_HYS_LSB +: 4];
    wire logic       hubSel   = ctl_reg[CTL_HUB_BIT];

    // Clock line synchroniser; the first stage feeds only the second
    logic scl1_reg, scl2_reg, scl3_reg, sclLevel_reg, sclLevel_next;

    always_comb
    begin
        sclLevel_next = (scl2_reg == scl3_reg) ? scl3_reg : sclLevel_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            scl1_reg     <= 1'b1;
            scl2_reg     <= 1'b1;
            scl3_reg     <= 1'b1;
            sclLevel_reg <= 1'b1;
        end
        else
        begin
            scl1_reg     <= sclPin;
            scl2_reg     <= scl1_reg;
            scl3_reg     <= scl2_reg;
            sclLevel_reg <= sclLevel_next;
        end
    end

    // Poll sequencer and status flags
    smbpc_state_t    state_reg, state_next;
    logic [2:0]      slave_reg, slave_next;
    logic [TO_W-1:0] toCnt_reg, toCnt_next;
    smbpc_res_t      res_reg, res_next;
    smbpc_req_t      pollReq_next;
    logic            pollStart_next, pollAbort_next, nackAlert_next;
    logic [7:0]      nack_reg, nack_next, pecErr_reg, pecErr_next, to_reg, to_next;
    logic [7:0]      lim_reg, lim_next, inv_reg, inv_next;
    logic            memWr;
    logic [7:0]      memData;
    smbpc_fmt_t      curFmt;
    logic [7:0]      polled;
    logic signed [9:0] tVal, hiVal, loVal, hysVal;
    logic            badRead, outNow, inBand;

    always_comb
    begin
        state_next     = state_reg;
        slave_next     = slave_reg;
        toCnt_next     = toCnt_reg;
        res_next       = res_reg;
        pollReq_next   = pollReq;
        pollStart_next = 1'b0;
        pollAbort_next = 1'b0;
        nack_next      = nack_reg;
        pecErr_next    = pecErr_reg;
        to_next        = to_reg;
        lim_next       = lim_reg;
        inv_next       = inv_reg;
        memWr          = 1'b0;
        curFmt         = fmtOf(slave_reg, fmtLo_reg, fmtHi_reg);
        // SPD readings carry the whole degrees in bits 11:4
        polled  = (curFmt == FMT_JEDEC) ? res_reg.data[11:4] : res_reg.data[7:0];
        memData = polled;
        if (!hubSel && ctl_reg[CTL_REMA_BIT] && (slave_reg == 3'h1 || slave_reg == 3'h2))
        begin
            memData = remoteTempA;
        end
        else if (!hubSel && ctl_reg[CTL_REMB_BIT] && (slave_reg == 3'h3 || slave_reg == 3'h4))
        begin
            memData = remoteTempB;
        end
        // Straight binary compares unsigned; every other format is signed
        tVal    = (curFmt == FMT_UNSIGNED) ? {2'b00, memData} : {{2{memData[7]}}, memData};
        hiVal   = {2'b00, hiLim_reg};
        loVal   = {{2{loLim_reg[7]}}, loLim_reg};
        outNow  = (tVal > hiVal) || (tVal < loVal);
        // Kept signed so negative readings are not compared as large unsigned values
        hysVal  = {6'h00, hys};
        inBand  = (tVal <= hiVal - hysVal) && (tVal >= loVal + hysVal);
        badRead = res_reg.noAck || res_reg.timeout || (res_reg.pecErr && pec_reg[slave_reg]);
        case (state_reg)
            ST_IDLE:
            begin
                slave_next = 3'h0;
                if (masterEn)
                begin
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                if (!masterEn)
                begin
                    state_next = ST_IDLE;
                end
                else
                begin
                    pollReq_next.slave    = slave_reg;
                    pollReq_next.repStart = rs_reg[slave_reg];
                    pollReq_next.pecEn    = pec_reg[slave_reg];
                    pollReq_next.fmt      = curFmt;
                    pollReq_next.blockRead = (slave_reg < 3'h4) && (curFmt == FMT_SPECIAL);
                    pollReq_next.literal  = (slave_reg > 3'h4) && (curFmt == FMT_SPECIAL);
                    pollReq_next.fromHub  = hubSel && isDimm(slave_reg);
                    pollReq_next.blockCmd = cmd_reg;
                    pollStart_next = 1'b1;
                    toCnt_next     = '0;
                    state_next     = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (!masterEn)
                begin
                    pollAbort_next = 1'b1;
                    state_next     = ST_IDLE;
                end
                else if (pollDone && pollResult.slave == slave_reg)
                begin
                    res_next   = pollResult;
                    state_next = ST_UPDATE;
                end
                else if (toCnt_reg == TO_W'(TIMEOUT_CYC))
                begin
                    // The engine is stuck on a held-low clock; end the poll here
                    res_next         = '0;
                    res_next.slave   = slave_reg;
                    res_next.timeout = 1'b1;
                    pollAbort_next   = 1'b1;
                    state_next       = ST_UPDATE;
                end
                else
                begin
                    toCnt_next = sclLevel_reg ? '0 : toCnt_reg + TO_W'(1);
                end
            end
            ST_UPDATE:
            begin
                nack_next[slave_reg]   = res_reg.noAck;
                pecErr_next[slave_reg] = res_reg.pecErr && pec_reg[slave_reg];
                to_next[slave_reg]     = res_reg.timeout;
                if (!badRead)
                begin
                    memWr = 1'b1;
                    lim_next[slave_reg] = outNow || (lim_reg[slave_reg] && !inBand);
                    if (slave_reg < 3'h5)
                    begin
                        inv_next[slave_reg] = (slave_reg == 3'h0 || (hubSel && isDimm(slave_reg)))
                                              && (polled == RESERVED_TEMP_CODE);
                    end
                end
                slave_next = slave_reg + 3'h1;
                state_next = masterEn ? ST_ISSUE : ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        inv_next       = inv_next & INVALID_USED_MASK;
        nackAlert_next = |(nack_reg & ~mask_reg);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg  <= ST_IDLE;
            slave_reg  <= 3'h0;
            toCnt_reg  <= '0;
            res_reg    <= '0;
            pollReq    <= '0;
            pollStart  <= 1'b0;
            pollAbort  <= 1'b0;
            nackAlert  <= 1'b0;
            nack_reg   <= RST_FLAGS;
            pecErr_reg <= RST_FLAGS;
            to_reg     <= RST_FLAGS;
            lim_reg    <= RST_FLAGS;
            inv_reg    <= RST_FLAGS;
        end
        else
        begin
            state_reg  <= state_next;
            slave_reg  <= slave_next;
            toCnt_reg  <= toCnt_next;
            res_reg    <= res_next;
            pollReq    <= pollReq_next;
            pollStart  <= pollStart_next;
            pollAbort  <= pollAbort_next;
            nackAlert  <= nackAlert_next;
            nack_reg   <= nack_next;
            pecErr_reg <= pecErr_next;
            to_reg     <= to_next;
            lim_reg    <= lim_next;
            inv_reg    <= inv_next;
        end
    end

    // Register read path: address captured, result memory answers a cycle later
    logic [7:0] memRdData, rdAddr_reg, rdAddr_next, regRdData_next;
    logic       rdPend_reg, rdPend_next, regRdValid_next;

    smbpc_result_mem #(
        .DEPTH (8),
        .WIDTH (8)
    ) u_result_mem (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wrEn    (memWr),
        .wrAddr  (slave_reg),
        .wrData  (memData),
        .rdAddr  (regAddr[2:0]),
        .rdData  (memRdData)
    );

    always_comb
    begin
        rdPend_next     = regRd;
        rdAddr_next     = regRd ? regAddr : rdAddr_reg;
        regRdValid_next = rdPend_reg;
        regRdData_next  = regRdData;
        if (rdPend_reg)
        begin
            case (rdAddr_reg)
                ADDR_RS:        regRdData_next = rs_reg;
                ADDR_PEC:       regRdData_next = pec_reg;
                ADDR_FMT_LO:    regRdData_next = fmtLo_reg;
                ADDR_FMT_HI:    regRdData_next = fmtHi_reg;
                ADDR_CTL:       regRdData_next = ctl_reg;
                ADDR_CMD_CODE:  regRdData_next = cmd_reg;
                ADDR_NACK:      regRdData_next = nack_reg;
                ADDR_PEC_ERR:   regRdData_next = pecErr_reg;
                ADDR_TIMEOUT:   regRdData_next = to_reg;
                ADDR_LIMIT:     regRdData_next = lim_reg;
                ADDR_INVALID:   regRdData_next = inv_reg;
                ADDR_NACK_MASK: regRdData_next = mask_reg;
                ADDR_HIGH_LIM:  regRdData_next = hiLim_reg;
                ADDR_LOW_LIM:   regRdData_next = loLim_reg;
                default:
                begin
                    regRdData_next = (rdAddr_reg[7:3] == ADDR_RESULT_BASE[7:3]) ? memRdData
                                                                                : 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdPend_reg <= 1'b0;
            rdAddr_reg <= 8'h00;
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            rdPend_reg <= rdPend_next;
            rdAddr_reg <= rdAddr_next;
            regRdData  <= regRdData_next;
            regRdValid <= regRdValid_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence seqUpdate;
        state_reg == ST_UPDATE;
    endsequence

    sequence seqStart;
        pollStart && !$past(srst);
    endsequence

    AST_START_NEEDS_ENABLE: assert property (seqStart |-> $past(masterEn))
        else $error("poll started while master disabled");
    AST_DISABLE_HALTS: assert property (!masterEn ##1 !masterEn |=> !pollStart [*2])
        else $error("poll started after master disabled");
    AST_RS_FIELD: assert property (seqStart |-> pollReq.repStart == $past(rs_reg[slave_reg]))
        else $error("repeated-start bit does not match enable");
    AST_PEC_FIELD: assert property (seqStart |-> pollReq.pecEn == $past(pec_reg[slave_reg]))
        else $error("checksum bit does not match enable");
    AST_HUB_SOURCE: assert property (seqStart
        |-> pollReq.fromHub == ($past(hubSel) && isDimm(pollReq.slave)))
        else $error("DIMM source does not follow hub select");
    AST_BLOCK_READ: assert property (seqStart and pollReq.fmt == FMT_SPECIAL
        |-> pollReq.blockRead == (pollReq.slave < 3'h4))
        else $error("code 11 block-read selection wrong");
    // A masked slave may leave the alert low; an unmasked one must raise it
    AST_NACK_FLAG: assert property (seqUpdate and res_reg.noAck
        |=> nack_reg[$past(slave_reg)] ##1 (mask_reg[$past(slave_reg, 2)] || nackAlert))
        else $error("no-acknowledge flag or alert not raised");
    AST_TIMEOUT_FLAG: assert property (seqUpdate and res_reg.timeout
        |=> to_reg[$past(slave_reg)])
        else $error("timeout flag not raised");
    AST_INVALID_RESERVED: assert property (inv_reg[7:5] == 3'b000)
        else $error("reserved invalid-code bits set");
    AST_TIMEOUT_COUNT: assert property (state_reg == ST_WAIT && masterEn && !pollDone
        && toCnt_reg == TO_W'(TIMEOUT_CYC) |=> pollAbort && state_reg == ST_UPDATE)
        else $error("stuck clock did not end the poll");

endmodule : smbpc_top

`default_nettype wire

// file: testbench/smbpc_engine_model.sv
`timescale 1ns/1ns
`default_nettype none

// Stands in for the bus engine and the polled sensors behind it
module smbpc_engine_model
    import smbpc_pkg::*;
(
    input  wire logic       sys_clk,
    input  var  smbpc_req_t pollReq,
    input  wire logic       pollStart,
    input  wire logic [7:0] nackSel,
    input  wire logic [7:0] tempVal,
    input  wire logic       stall,
    output var  logic       pollDone,
    output var  smbpc_res_t pollResult,
    output var  logic       busy
);
    initial
    begin
        pollDone = 1'b0;
        pollResult = '0;
        busy = 1'b0;
        forever
        begin
            @(negedge sys_clk);
            if (pollStart === 1'b1)
            begin
                busy = 1'b1;
                // Varying latency so no fixed answer time is relied on
                repeat ($urandom_range(6, 2)) @(negedge sys_clk);
                // A stalled sensor never answers; the design's timeout must end the poll
                if (!stall)
                begin
                    pollResult = '{pollReq.slave, nackSel[pollReq.slave], 1'b0, 1'b0,
                                   {tempVal, tempVal}};
                    pollDone = 1'b1;
                    @(negedge sys_clk);
                    pollDone = 1'b0;
                end
                // Released lines show the inverse of their previous value, not the answer just given
                pollResult = ~pollResult;
                busy = 1'b0;
            end
        end
    end
endmodule : smbpc_engine_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import smbpc_pkg::*;
    localparam logic [15:0] FMTW = 16'hfbe4;
    localparam logic [7:0]  RA [12] = '{ADDR_RS, ADDR_PEC, ADDR_FMT_LO, ADDR_FMT_HI, ADDR_CTL,
        ADDR_NACK, ADDR_PEC_ERR, ADDR_TIMEOUT, ADDR_LIMIT, ADDR_INVALID, ADDR_CMD_CODE, 8'hb4};
    localparam logic [7:0]  RE [12] = '{8'hff, 8'h00, 8'h03, 8'h00, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    logic       sys_clk, srst, regWr, regRd, sclPin, pollDone, busy, sclStuck;
    logic       regRdValid, pollStart, pollAbort, nackAlert;
    logic [7:0] regAddr, regWrData, regRdData, remoteTempA, remoteTempB, nackSel, tempVal;
    logic [7:0] rsVal, pecVal;
    logic [7:0] res [8] = '{default: 8'h80};
    logic [7:0] expQ [$];
    smbpc_res_t pollResult;
    smbpc_req_t pollReq;
    int         errors = 0;
    int         n_compared = 0;
    int         cycles = 0;

    smbpc_top #(.TIMEOUT_CYC(50)) u_smbpc_top (.sys_clk(sys_clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .regRdValid(regRdValid), .sclPin(sclPin),
        .remoteTempA(remoteTempA), .remoteTempB(remoteTempB), .pollDone(pollDone),
        .pollResult(pollResult), .pollReq(pollReq), .pollStart(pollStart),
        .pollAbort(pollAbort), .nackAlert(nackAlert));
    smbpc_engine_model u_smbpc_engine_model (.sys_clk(sys_clk), .pollReq(pollReq),
        .pollStart(pollStart), .nackSel(nackSel), .tempVal(tempVal), .pollDone(pollDone),
        .pollResult(pollResult), .busy(busy), .stall(sclStuck));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Bus clock runs only within a poll and idles high on its pull-up
    initial
    begin
        sclPin = 1'b1;
        #3;
        // A stuck sensor holds the line low so the poll timeout is reached
        forever #80 sclPin = sclStuck ? 1'b0 : (busy ? ~sclPin : 1'b1);
    end

    task automatic stop_test();
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors = errors + 1;
            stop_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge sys_clk);
        regWr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRd = 1'b1;
        expQ.push_back(e);
        @(negedge sys_clk);
        regRd = 1'b0;
    endtask : rd

    always @(negedge sys_clk)
        if (regRdValid === 1'b1)
            check(regRdData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);

    task automatic wait_on(input int which);
        int n;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end while ((which ? pollAbort : pollStart) !== 1'b1 && n < 60);
        check({7'h0, which ? pollAbort : pollStart}, 8'h01);
    endtask : wait_on

    task automatic sweep(input logic [7:0] c, input logic [7:0] nk);
        logic [2:0] s, s0;
        logic [1:0] f;
        logic [7:0] lim, t;
        int         i;
        lim = 8'h00;
        nackSel = nk;
        remoteTempA = $urandom;
        remoteTempB = $urandom;
        wr(ADDR_NACK_MASK, 8'h00);
        wr(ADDR_CTL, c);
        for (i = 0; i < 8; i++)
        begin
            wait_on(0);
            s = pollReq.slave;
            if (i == 0)
                s0 = s;
            check({5'h0, s}, {5'h0, s0 + 3'(i)});
            f = FMTW[2*s +: 2];
            t = (c[7] && s == 0) ? 8'hff : 8'($urandom_range(254));
            tempVal = t;
            check({pollReq.repStart, pollReq.pecEn, pollReq.blockRead, pollReq.literal,
                pollReq.fromHub, pollReq.fmt, 1'b0}, {rsVal[s], pecVal[s], s < 4 && f == 2'b11,
                s > 4 && f == 2'b11, c[7] && s inside {[1:4]}, f, 1'b0});
            if (s == 0)
                check(pollReq.blockCmd, 8'hbf);
            t = (f == 2'b01) ? {t[3:0], t[7:4]} : t;
            if (!c[7] && c[5] && s inside {1, 2})
                t = remoteTempA;
            if (!c[7] && c[6] && s inside {3, 4})
                t = remoteTempB;
            if (!nk[s])
            begin
                res[s] = t;
                // Signed readings fall outside only at -128, below the low limit
                lim[s] = (f == 2'b10) ? t > 8'h7f : t == 8'h80;
            end
        end
        wait_on(0);
        wr(ADDR_CTL, 8'h00);
        wait_on(1);
        repeat (20) @(negedge sys_clk);
        check({7'h0, nackAlert}, {7'h0, |nk});
        rd(ADDR_NACK, nk);
        rd(ADDR_PEC_ERR, 8'h00);
        rd(ADDR_TIMEOUT, 8'h00);
        if (c[7:5] == 3'b000)
            rd(ADDR_LIMIT, lim);
        rd(ADDR_INVALID, {7'h0, c[7] && !nk[0]});
        for (i = c[7] ? 5 : 0; i < 8; i++)
            rd(ADDR_RESULT_BASE + 8'(i), res[i]);
        wr(ADDR_NACK_MASK, nk);
        repeat (3) @(negedge sys_clk);
        check({7'h0, nackAlert}, 8'h00);
    endtask : sweep

    initial
    begin
        srst = 1'b1;
        {regWr, regRd, regAddr, regWrData, remoteTempA, remoteTempB, nackSel, tempVal} = '0;
        sclStuck = 1'b0;
        rsVal = $urandom(32'hc2eacd71);
        pecVal = $urandom;
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        // Writes to read-only places first, so the reset table also shows them refused
        for (int i = 5; i < 10; i++)
            wr(RA[i], 8'hff);
        wr(ADDR_RESULT_BASE, 8'h11);
        foreach (RA[i])
            rd(RA[i], RE[i]);
        for (int i = 0; i < 8; i++)
            rd(ADDR_RESULT_BASE + 8'(i), 8'h80);
        wr(ADDR_RS, rsVal);
        wr(ADDR_PEC, pecVal);
        wr(ADDR_FMT_LO, FMTW[7:0]);
        wr(ADDR_FMT_HI, FMTW[15:8]);
        wr(ADDR_CMD_CODE, 8'hbf);
        rd(ADDR_RS, rsVal);
        rd(ADDR_PEC, pecVal);
        rd(ADDR_FMT_HI, FMTW[15:8]);
        sweep(8'h01, 8'($urandom));
        sweep(8'h61, 8'h00);
        sweep(8'he1, 8'($urandom));
        sclStuck = 1'b1;
        repeat (20) @(negedge sys_clk);
        wr(ADDR_CTL, 8'h01);
        wait_on(0);
        wait_on(1);
        wr(ADDR_CTL, 8'h00);
        rd(ADDR_TIMEOUT, 8'h01);
        rd(ADDR_RESULT_BASE, res[0]);
        repeat (6) @(negedge sys_clk);
        check(8'(expQ.size()), 8'h00);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
